// [src/led_scan_pkg.sv]
// package: register map, field layout and scan constants of the led scanner
package led_scan_pkg;
  localparam logic [7:0] HALF_BIAS_OFS = 8'h92;
  localparam logic [7:0] SCAN_CTRL_OFS = 8'hB1;
  localparam logic [7:0] BRIGHT_CTRL_OFS = 8'hB2;
  localparam logic [7:0] DOT_CTRL_OFS = 8'hB3;
  localparam logic [7:0] SCAN_STAT_OFS = 8'hB4;
  localparam logic [15:0] DISP_BASE = 16'hC800;
  localparam int DISP_BYTES = 8;
  localparam logic [7:0] HALF_BIAS_RST = 8'h00;
  localparam logic [7:0] SCAN_CTRL_RST = 8'h04;
  localparam logic [7:0] BRIGHT_CTRL_RST = 8'h44;
  localparam logic [7:0] DOT_CTRL_RST = 8'h00;
  // field positions
  localparam int DUTY_POS = 6;
  localparam int DIV_POS = 4;
  localparam int FREEZE_POS = 3;
  localparam int MAIN_POS = 0;
  localparam int STYLE_POS = 7;
  localparam int ODD_POS = 4;
  localparam int EVEN_POS = 0;
  localparam int DOT_ON_POS = 0;
  localparam int DOT_SIZE_POS = 4;
  localparam logic [7:0] BRIGHT_CTRL_MASK = 8'hF7;
  localparam logic [7:0] DOT_CTRL_MASK = 8'h71;
  // scan clock divisors for codes 00..11
  localparam logic [6:0] DIV_C0 = 7'h40;
  localparam logic [6:0] DIV_C1 = 7'h20;
  localparam logic [6:0] DIV_C2 = 7'h10;
  localparam logic [6:0] DIV_C3 = 7'h08;
  // one slot is dead time plus eight brightness ticks
  localparam logic [3:0] DEAD_TICKS = 4'h1;
  localparam logic [3:0] BRIGHT_TICKS = 4'h8;
  localparam logic [3:0] SLOT_TICKS = DEAD_TICKS + BRIGHT_TICKS;
  localparam int PINS = 10;
  localparam int COM_BASE = 0;
  localparam int SEG_BASE = 4;

  typedef enum logic [1:0] {MODE_OFF, MODE_BID, MODE_DOT} scan_mode_t;

  typedef struct packed {
    logic [PINS-1:0] level;
    logic [PINS-1:0] oe;
  } pin_drive_t;
endpackage

// [src/led_matrix_scan_driver.sv]
// led matrix scanner: registers, display memory, scan timing and pin drive
// Summary of operation
// - only one drive mode active at a time
// - bidirectional: ten pins drive up to 48 leds
// - lit pins go inactive for dead time
// - nonzero duty starts scan and takes pins
// - duty code selects 4x4, 4x5, 4x6
// - six display bytes, led equals 8*byte+bit
// - nibble and byte 4/5 polarity mapping
// - main, even and odd brightness groups
// - 3-bit brightness, 000 darkest, 111 brightest
// - dot mode when dot enable set
// - dot mode reads eight bytes, 1 lights
// - size select keeps led addresses fixed
// - dot mode uses odd group brightness
// - style bit: uniform or enhanced brightness
// - prescaler divides by 64, 32, 16, 8
// - freeze bit stops the scan clock
// - per-pin half-bias lcd common enables
`timescale 1ns/1ps
module led_matrix_scan_driver (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] disp_addr_i,
  input wire logic [7:0] disp_wdata_i,
  input wire logic disp_wr_i,
  input wire logic disp_rd_i,
  output logic [7:0] disp_rdata_o,
  output led_scan_pkg::pin_drive_t led_drive_o,
  output logic [7:0] lcd_half_bias_en_o
);

  function automatic logic [6:0] div_of(input logic [1:0] code);
    case (code)
      2'b00: div_of = led_scan_pkg::DIV_C0;
      2'b01: div_of = led_scan_pkg::DIV_C1;
      2'b10: div_of = led_scan_pkg::DIV_C2;
      default: div_of = led_scan_pkg::DIV_C3;
    endcase
  endfunction

  // rows of the dot matrix for size codes 0..4; larger codes read as 8x8
  function automatic logic [3:0] rows_of(input logic [2:0] size);
    rows_of = (size > 3'h4) ? 4'h8 : 4'(size) + 4'h4;
  endfunction

  function automatic logic bright_on(input logic [2:0] lvl,
                                     input logic [2:0] bsub,
                                     input logic style);
    if (style) begin
      bright_on = ({1'b0, bsub[2:1]} <= lvl);
    end else begin
      bright_on = (bsub <= lvl);
    end
  endfunction

  logic [7:0] half_bias;
  logic [7:0] scan_ctrl;
  logic [7:0] bright_ctrl;
  logic [7:0] dot_ctrl;
  logic [7:0] disp_mem [led_scan_pkg::DISP_BYTES];
  logic [6:0] pre_cnt;
  logic [3:0] sub;
  logic [3:0] phase;
  led_scan_pkg::pin_drive_t next_drive;

  // register fields
  wire [1:0] bid_duty_sel = scan_ctrl[led_scan_pkg::DUTY_POS +: 2];
  wire [1:0] scan_clk_div = scan_ctrl[led_scan_pkg::DIV_POS +: 2];
  wire scan_clk_freeze = scan_ctrl[led_scan_pkg::FREEZE_POS];
  wire [2:0] bright_main = scan_ctrl[led_scan_pkg::MAIN_POS +: 3];
  wire bright_style = bright_ctrl[led_scan_pkg::STYLE_POS];
  wire [2:0] bright_group_odd = bright_ctrl[led_scan_pkg::ODD_POS +: 3];
  wire [2:0] bright_group_even = bright_ctrl[led_scan_pkg::EVEN_POS +: 3];
  wire dotmatrix_on = dot_ctrl[led_scan_pkg::DOT_ON_POS];
  wire [2:0] dotmatrix_size_sel = dot_ctrl[led_scan_pkg::DOT_SIZE_POS +: 3];

  // dot mode has priority so the two modes never share the pins
  led_scan_pkg::scan_mode_t mode;
  assign mode = dotmatrix_on ? led_scan_pkg::MODE_DOT :
                (bid_duty_sel != 2'b00) ? led_scan_pkg::MODE_BID :
                led_scan_pkg::MODE_OFF;
  wire scan_act = (mode != led_scan_pkg::MODE_OFF);

  // bid: two polarities per common, plus one phase per extra segment
  wire [3:0] bid_phases = 4'h7 + {2'b00, bid_duty_sel};
  wire [3:0] dot_rows = rows_of(dotmatrix_size_sel);
  wire [3:0] phase_count = (mode == led_scan_pkg::MODE_DOT) ?
                           dot_rows : bid_phases;

  // address decode
  wire sel_half = (reg_addr_i == led_scan_pkg::HALF_BIAS_OFS);
  wire sel_scan = (reg_addr_i == led_scan_pkg::SCAN_CTRL_OFS);
  wire sel_bright = (reg_addr_i == led_scan_pkg::BRIGHT_CTRL_OFS);
  wire sel_dot = (reg_addr_i == led_scan_pkg::DOT_CTRL_OFS);
  wire sel_stat = (reg_addr_i == led_scan_pkg::SCAN_STAT_OFS);
  wire [7:0] stat_word = {2'b00, mode, phase};
  wire [7:0] rd_word =
    sel_half ? half_bias :
    sel_scan ? scan_ctrl :
    sel_bright ? bright_ctrl :
    sel_dot ? dot_ctrl :
    sel_stat ? stat_word : 8'h00;
  wire [15:0] disp_ofs = disp_addr_i - led_scan_pkg::DISP_BASE;
  wire disp_hit = (disp_ofs < 16'(led_scan_pkg::DISP_BYTES));
  wire [2:0] disp_idx = disp_ofs[2:0];

  assign lcd_half_bias_en_o = half_bias;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      half_bias <= led_scan_pkg::HALF_BIAS_RST;
      scan_ctrl <= led_scan_pkg::SCAN_CTRL_RST;
      bright_ctrl <= led_scan_pkg::BRIGHT_CTRL_RST;
      dot_ctrl <= led_scan_pkg::DOT_CTRL_RST;
    end else if (reg_wr_i) begin
      if (sel_half) begin
        half_bias <= reg_wdata_i;
      end else if (sel_scan) begin
        scan_ctrl <= reg_wdata_i;
      end else if (sel_bright) begin
        bright_ctrl <= reg_wdata_i & led_scan_pkg::BRIGHT_CTRL_MASK;
      end else if (sel_dot) begin
        dot_ctrl <= reg_wdata_i & led_scan_pkg::DOT_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
      disp_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_word : 8'h00;
      disp_rdata_o <= (disp_rd_i && disp_hit) ? disp_mem[disp_idx] : 8'h00;
    end
  end

  // display memory has no reset; software fills it before enabling a mode
  always_ff @(posedge ref_clk_i) begin
    if (disp_wr_i && disp_hit) begin
      disp_mem[disp_idx] <= disp_wdata_i;
    end
  end

  // scan clock: one-cycle tick every div_of() clocks, held while frozen
  wire [6:0] div_now = div_of(scan_clk_div);
  wire scan_tick = scan_act && !scan_clk_freeze &&
                   (pre_cnt >= div_now - 7'h01);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_cnt <= 7'h00;
    end else if (!scan_act || scan_tick) begin
      pre_cnt <= 7'h00;
    end else if (!scan_clk_freeze) begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  // slot and phase counters advance only on scan ticks
  wire slot_end = (sub == led_scan_pkg::SLOT_TICKS - 4'h1);
  wire last_phase = (phase >= phase_count - 4'h1);
  wire phase_over = (phase >= phase_count);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sub <= 4'h0;
      phase <= 4'h0;
    end else if (!scan_act) begin
      sub <= 4'h0;
      phase <= 4'h0;
    end else if (phase_over) begin
      // a smaller size or duty restarts the frame instead of running on
      phase <= 4'h0;
    end else if (scan_tick) begin
      sub <= slot_end ? 4'h0 : sub + 4'h1;
      if (slot_end) begin
        phase <= last_phase ? 4'h0 : phase + 4'h1;
      end
    end
  end

  wire dead = (sub < led_scan_pkg::DEAD_TICKS);
  wire [2:0] bsub = 3'(sub - led_scan_pkg::DEAD_TICKS);
  wire [1:0] cidx = phase[2:1];
  wire [7:0] byte_c = disp_mem[cidx];
  wire [7:0] byte4 = disp_mem[4];
  wire [7:0] byte5 = disp_mem[5];
  wire [7:0] row_byte = disp_mem[phase[2:0]];
  wire [3:0] dot_cols = (dot_rows == 4'h8) ? 4'h8 : dot_rows + 4'h1;

  wire on_main = bright_on(bright_main, bsub, bright_style);
  wire on_even = bright_on(bright_group_even, bsub, bright_style);
  wire on_odd = bright_on(bright_group_odd, bsub, bright_style);

  // segment pins in use for the selected duty
  wire [5:0] seg_used = (bid_duty_sel == 2'b11) ? 6'h3F :
                        (bid_duty_sel == 2'b10) ? 6'h1F : 6'h0F;

  // pin index 0..3 are commons, 4..9 segments; the driving pin sits at
  // its polarity level and lit pins at the opposite one after dead time
  always_comb begin
    next_drive = '0;
    if (mode == led_scan_pkg::MODE_BID) begin
      if (phase < 4'h8) begin
        next_drive.oe[cidx] = 1'b1;
        next_drive.level[cidx] = !phase[0];
        for (int s = 0; s < 4; s++) begin
          next_drive.level[led_scan_pkg::SEG_BASE + s] = phase[0];
          next_drive.oe[led_scan_pkg::SEG_BASE + s] = !dead && on_main &&
            (phase[0] ? byte_c[4 + s] : byte_c[s]);
        end
        if (!phase[0]) begin
          next_drive.oe[led_scan_pkg::SEG_BASE + 4] = !dead && on_even &&
            seg_used[4] && byte4[{cidx, 1'b0}];
          next_drive.oe[led_scan_pkg::SEG_BASE + 5] = !dead && on_odd &&
            seg_used[5] && byte4[{cidx, 1'b1}];
        end
      end else begin
        next_drive.oe[led_scan_pkg::SEG_BASE + 4 + 32'(phase[0])] = 1'b1;
        next_drive.level[led_scan_pkg::SEG_BASE + 4 + 32'(phase[0])] = 1'b1;
        for (int c = 0; c < 4; c++) begin
          next_drive.oe[led_scan_pkg::COM_BASE + c] = !dead && on_main &&
            byte5[{phase[0], 2'(c)}];
        end
      end
    end else if (mode == led_scan_pkg::MODE_DOT) begin
      next_drive.oe[phase] = 1'b1;
      next_drive.level[phase] = 1'b1;
      for (int c = 0; c < 8; c++) begin
        if (c < 32'(dot_cols)) begin
          next_drive.oe[(c < 32'(phase)) ? c : c + 1] = !dead && on_odd &&
            row_byte[c];
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      led_drive_o <= '0;
    end else begin
      led_drive_o <= next_drive;
    end
  end

  // checks
  property p_one_mode;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (dotmatrix_on && bid_duty_sel != 2'b00) |=>
        $onehot0(led_drive_o.level);
  endproperty
  a_one_mode: assert property (p_one_mode)
    else $error("both modes active");

  property p_dead_quiet;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && phase < 4'h8 && dead) |=>
        led_drive_o.oe[9:4] == 6'h00;
  endproperty
  a_dead_quiet: assert property (p_dead_quiet)
    else $error("segments driven in dead time");

  property p_takeover;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && phase < 4'h8) |=>
        led_drive_o.oe[3:0] != 4'h0;
  endproperty
  a_takeover: assert property (p_takeover)
    else $error("no common driven while scanning");

  property p_phase_range;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && $stable(bid_duty_sel)) |->
        phase < bid_phases;
  endproperty
  a_phase_range: assert property (p_phase_range)
    else $error("phase beyond duty");

  sequence s_quiet7;
    !scan_tick [*7];
  endsequence
  property p_div8;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (scan_tick && scan_clk_div == 2'b11) ##1
        (scan_clk_div == 2'b11 && !scan_clk_freeze && scan_act) [*8] |->
        scan_tick;
  endproperty
  a_div8: assert property (p_div8)
    else $error("scan tick period not 8");

  property p_tick_gap;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      scan_tick |=> s_quiet7;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("scan ticks closer than 8");

  property p_freeze;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (scan_clk_freeze && !phase_over) |=>
        ($stable(phase) && $stable(sub)) || !scan_act;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("scan moved while frozen");

  property p_dot_rows;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_DOT && $stable(dot_ctrl)) |->
        phase < dot_rows;
  endproperty
  a_dot_rows: assert property (p_dot_rows)
    else $error("dot row beyond size");

  property p_dark;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && phase < 4'h8 && !bright_style &&
       bright_main == 3'h0 && sub == 4'h2) |->
        next_drive.oe[7:4] == 4'h0;
  endproperty
  a_dark: assert property (p_dark)
    else $error("level 0 lit beyond first tick");

  property p_half_bias;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (reg_wr_i && sel_half) |=> lcd_half_bias_en_o == $past(reg_wdata_i);
  endproperty
  a_half_bias: assert property (p_half_bias)
    else $error("half bias enable not stored");

  property p_mode_off;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      mode == led_scan_pkg::MODE_OFF |=> led_drive_o == '0;
  endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("pins driven while scanning is off");

  property p_seg_unused;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && bid_duty_sel == 2'b01 &&
       $stable(bid_duty_sel)) |=> led_drive_o.oe[9:8] == 2'b00;
  endproperty
  a_seg_unused: assert property (p_seg_unused)
    else $error("segment beyond duty driven");

  property p_full_level;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && phase == 4'h0 && !dead &&
       bright_main == 3'h7 && byte_c[0]) |-> next_drive.oe[4];
  endproperty
  a_full_level: assert property (p_full_level)
    else $error("level 7 dark in a brightness tick");

  property p_one_common;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && phase < 4'h8) |=>
        led_drive_o.oe[3:0] == (4'h1 << $past(cidx));
  endproperty
  a_one_common: assert property (p_one_common)
    else $error("wrong common driven");

  property p_odd_level;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_BID && phase < 4'h8 && phase[0]) |=>
        led_drive_o.level == 10'h0F0;
  endproperty
  a_odd_level: assert property (p_odd_level)
    else $error("reverse polarity levels wrong");

  property p_dot_row_pin;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (mode == led_scan_pkg::MODE_DOT && phase < dot_rows) |=>
        led_drive_o.level == (10'h001 << $past(phase));
  endproperty
  a_dot_row_pin: assert property (p_dot_row_pin)
    else $error("dot row pin level wrong");

endmodule

// [bench/led_matrix_model.sv]
// partner: led matrix on the ten scan pins, reports conducting pixels
`timescale 1ns/1ps
module led_matrix_model (
  input wire led_scan_pkg::pin_drive_t drive_i,
  output logic [99:0] lit_o
);
  // a pixel conducts only with anode driven high and cathode driven low;
  // a released pin floats and so can never light anything
  always_comb begin
    for (int a = 0; a < 10; a++) begin
      for (int k = 0; k < 10; k++) begin
        lit_o[a*10+k] = drive_i.oe[a] & drive_i.level[a] &
                        drive_i.oe[k] & ~drive_i.level[k];
      end
    end
  end
endmodule

// [bench/led_matrix_scan_driver_tb_top.sv]
// testbench: register and display access, scan timing through matrix model
`timescale 1ns/1ps
module led_matrix_scan_driver_tb_top;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [15:0] disp_addr_i = 16'h0000;
  logic [7:0] disp_wdata_i = 8'h00;
  logic disp_wr_i = 1'b0;
  logic disp_rd_i = 1'b0;
  logic [7:0] disp_rdata_o;
  led_scan_pkg::pin_drive_t led_drive_o;
  led_scan_pkg::pin_drive_t snap;
  logic [7:0] lcd_half_bias_en_o;
  logic [99:0] lit;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  led_matrix_scan_driver dut (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .disp_addr_i(disp_addr_i),
    .disp_wdata_i(disp_wdata_i),
    .disp_wr_i(disp_wr_i),
    .disp_rd_i(disp_rd_i),
    .disp_rdata_o(disp_rdata_o),
    .led_drive_o(led_drive_o),
    .lcd_half_bias_en_o(lcd_half_bias_en_o)
  );

  led_matrix_model model (
    .drive_i(led_drive_o),
    .lit_o(lit)
  );

  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run needs roughly 26000 cycles
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail = n_fail + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one strobe cycle; a read checks data in the next cycle, then 0 after
  task automatic bus(input bit dsp, input bit wr, input logic [15:0] a,
                     input logic [7:0] d, input string what);
    @(posedge ref_clk_i);
    disp_addr_i <= a;
    disp_wdata_i <= d;
    reg_addr_i <= a[7:0];
    reg_wdata_i <= d;
    {disp_wr_i, disp_rd_i} <= dsp ? {wr, !wr} : 2'b00;
    {reg_wr_i, reg_rd_i} <= dsp ? 2'b00 : {wr, !wr};
    @(posedge ref_clk_i);
    {disp_wr_i, disp_rd_i, reg_wr_i, reg_rd_i} <= 4'h0;
    if (!wr) begin
      #1 chk(what, 32'(d), 32'(dsp ? disp_rdata_o : reg_rdata_o));
      @(posedge ref_clk_i);
      #1 chk(what, 32'h0, 32'(dsp ? disp_rdata_o : reg_rdata_o));
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, 1'b1, {8'h00, a}, d, "");
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, 1'b0, {8'h00, a}, e, "register read");
  endtask

  task automatic wdisp(input logic [2:0] i, input logic [7:0] d);
    bus(1'b1, 1'b1, led_scan_pkg::DISP_BASE + 16'(i), d, "");
  endtask

  // settle one frame, then count lit clocks of one pixel over one frame
  task automatic meas(input int a, input int k, input int flen,
                      input int exp);
    int n;
    n = 0;
    repeat (flen + 16) @(posedge ref_clk_i);
    repeat (flen) begin
      @(posedge ref_clk_i);
      #1 if (lit[a*10+k] === 1'b1) n++;
    end
    chk("lit clocks", 32'(exp), 32'(n));
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    #1 chk("pin enables", 32'h0, 32'(led_drive_o.oe));
    rreg(8'h92, 8'h00);
    rreg(8'hB1, 8'h04);
    rreg(8'hB2, 8'h44);
    rreg(8'hB3, 8'h00);
    rreg(8'hB4, 8'h00);
    wreg(8'h92, 8'hA5);
    #1 chk("half bias", 32'hA5, 32'(lcd_half_bias_en_o));
    rreg(8'h92, 8'hA5);
    wreg(8'h10, 8'hFF);
    rreg(8'h10, 8'h00);
    wreg(8'hB2, 8'hFF);
    rreg(8'hB2, 8'hF7);
    wreg(8'hB2, 8'h53);
    for (int i = 0; i < 8; i++) wdisp(3'(i), 8'h00);
    wdisp(3'd0, 8'h01);
    bus(1'b1, 1'b0, 16'hC800, 8'h01, "display read");
    // every nonzero duty code; frame length follows the phase count
    for (int d = 1; d < 4; d++) begin
      wreg(8'hB1, {2'(d), 2'b11, 1'b0, 3'b111});
      meas(0, 4, (7 + d) * 72, 64);
    end
    wreg(8'hB1, 8'hF0);
    meas(0, 4, 720, 8);
    wdisp(3'd0, 8'h10);
    meas(4, 0, 720, 8);
    wdisp(3'd0, 8'h00);
    wdisp(3'd4, 8'h03);
    meas(0, 8, 720, 32);
    meas(0, 9, 720, 48);
    wdisp(3'd4, 8'h00);
    wdisp(3'd5, 8'h01);
    meas(8, 0, 720, 8);
    wreg(8'hB1, 8'h37);
    repeat (20) @(posedge ref_clk_i);
    #1 chk("pin enables", 32'h0, 32'(led_drive_o.oe));
    // dot mode wins while bid mode is still enabled
    wdisp(3'd5, 8'h00);
    wdisp(3'd0, 8'h01);
    wreg(8'hB1, 8'hF7);
    wreg(8'hB2, 8'h70);
    wreg(8'hB3, 8'h41);
    meas(0, 1, 576, 64);
    meas(0, 4, 576, 0);
    wdisp(3'd0, 8'h00);
    wdisp(3'd7, 8'h80);
    meas(7, 8, 576, 64);
    wdisp(3'd7, 8'h00);
    wdisp(3'd0, 8'h01);
    wreg(8'hB3, 8'h01);
    meas(0, 1, 288, 64);
    wreg(8'hB2, 8'h10);
    meas(0, 1, 288, 16);
    wreg(8'hB2, 8'h90);
    meas(0, 1, 288, 32);
    wreg(8'hB2, 8'h70);
    for (int c = 0; c < 4; c++) begin
      wreg(8'hB1, {2'b11, 2'(c), 1'b0, 3'b111});
      meas(0, 1, 36 * (64 >> c), 8 * (64 >> c));
    end
    wreg(8'hB1, 8'hFF);
    repeat (20) @(posedge ref_clk_i);
    #1 snap = led_drive_o;
    repeat (300) @(posedge ref_clk_i);
    #1 chk("frozen drive", 32'(snap), 32'(led_drive_o));
    report_and_stop();
  end
endmodule
